// *** nfc_consts.svh ***
// Timing and protocol constants for the NAND host controller
`ifndef NFC_CONSTS_SVH
`define NFC_CONSTS_SVH

`define NFC_CLK_PERIOD_NS 10
`define NFC_ADDR_CYCLES 3'h5
`define NFC_PARTIAL_PROG_MAX 3'h4
`define NFC_ADL_NS 70
`define NFC_WP_NS 12
`define NFC_WH_NS 10
`define NFC_RP_NS 12
`define NFC_REH_NS 10
`define NFC_WHR_NS 60
`define NFC_WB_NS 100
`define NFC_PROG_MAX_US 700
`define NFC_ERASE_MAX_MS 10
`define NFC_RST_READY_US 5
`define NFC_DBSY_MAX_US 1
`define NFC_CMD_RESET 8'hff
`define NFC_CMD_PROG1 8'h80
`define NFC_CMD_PROG2 8'h10
`define NFC_CMD_ERASE1 8'h60
`define NFC_CMD_ERASE2 8'hd0
`define NFC_CMD_PLANE1 8'h11
`define NFC_CMD_PLANE2 8'h81
`define NFC_BLOCK_ADDR_W 12

`endif

// *** nfc_pkg.sv ***
// Types shared by the NAND host controller files
package nfc_pkg;

   typedef enum logic [2:0] {
      nfc_op_read,
      nfc_op_program,
      nfc_op_erase,
      nfc_op_reset,
      nfc_op_program_2p
   } nfc_op_t;

   typedef struct packed {
      nfc_op_t op;
      logic [7:0] cmd1;
      logic [7:0] cmd2;
      logic [39:0] addr;
      logic [15:0] data_len;
   } nfc_req_t;

   typedef struct packed {
      logic cle;
      logic ale;
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic lock_n;
   } nfc_ctl_t;

endpackage

// *** nfc_bad_mem.sv ***
// Invalid-block and partial-program memory with registered read data
`timescale 1ns/1ps
module nfc_bad_mem
   import nfc_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int DATA_W = 4
)(
   input wire logic ref_clk,
   input wire logic wr_en,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [DATA_W-1:0] rd_data
);
   logic [DATA_W-1:0] mem_reg [0:(1<<ADDR_W)-1];

   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         mem_reg[wr_addr] <= wr_data;
      end
      rd_data <= mem_reg[rd_addr];
   end
endmodule // nfc_bad_mem

// *** nfc_host.sv ***
// Host-side controller driving the NAND flash multiplexed bus
`timescale 1ns/1ps
`include "nfc_consts.svh"
module nfc_host
   import nfc_pkg::*;
#(
   parameter int CLK_NS = `NFC_CLK_PERIOD_NS,
   parameter int PROG_TMO = `NFC_PROG_MAX_US * 1000 / `NFC_CLK_PERIOD_NS,
   parameter int ERASE_TMO = `NFC_ERASE_MAX_MS * 1000000 / `NFC_CLK_PERIOD_NS,
   parameter int BLK_W = `NFC_BLOCK_ADDR_W
)(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic req_valid,
   output logic req_ready,
   input wire nfc_req_t req,
   input wire logic wdata_valid,
   output logic wdata_ready,
   input wire logic [7:0] wdata,
   output logic rdata_valid,
   output logic [7:0] rdata,
   output logic done,
   output logic timeout,
   output logic refused,
   input wire logic mark_bad,
   input wire logic [BLK_W-1:0] mark_blk,
   output nfc_ctl_t ctl,
   output logic [7:0] io_out,
   output logic io_oe_n,
   input wire logic [7:0] io_in,
   input wire logic ready_busy_n
);
   // ----------------------------------------------------------------
   // Timing counts
   // ----------------------------------------------------------------
   function automatic logic [15:0] ns_cyc(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      if (c < 1) c = 1;
      return 16'(c);
   endfunction

   localparam logic [15:0] WP_CYC = ns_cyc(`NFC_WP_NS);
   localparam logic [15:0] WH_CYC = ns_cyc(`NFC_WH_NS);
   localparam logic [15:0] RP_CYC = ns_cyc(`NFC_RP_NS);
   localparam logic [15:0] REH_CYC = ns_cyc(`NFC_REH_NS);
   localparam logic [15:0] ADL_CYC = ns_cyc(`NFC_ADL_NS);
   localparam logic [15:0] WHR_CYC = ns_cyc(`NFC_WHR_NS);
   localparam logic [15:0] WB_CYC = ns_cyc(`NFC_WB_NS);
   localparam logic [31:0] RST_TMO = 32'(`NFC_RST_READY_US * 1000 / `NFC_CLK_PERIOD_NS);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic rb_s1_reg, rb_reg;
   logic [7:0] io_s1_reg, io_reg;
   always_ff @(posedge ref_clk) begin
      rb_s1_reg <= ready_busy_n;
      rb_reg <= rb_s1_reg;
      io_s1_reg <= io_in;
      io_reg <= io_s1_reg;
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   typedef enum {
      s_idle, s_check, s_cmd1, s_addr, s_adl, s_data, s_cmd2, s_wb, s_busy,
      s_rd, s_plane, s_fin
   } nfc_state_t;

   nfc_state_t state_reg;
   nfc_req_t req_reg;
   nfc_ctl_t ctl_reg;
   logic [7:0] io_out_reg;
   logic io_oe_n_reg;
   logic [2:0] addr_cnt_reg;
   logic [15:0] len_reg;
   logic [15:0] tm_reg;
   logic [31:0] busy_reg;
   logic [1:0] phase_reg;
   logic plane2_reg;
   logic sent_reg;
   logic rdata_valid_reg, done_reg, timeout_reg, refused_reg;
   logic [7:0] rdata_reg;

   // Per-block record: bit 3 marks invalid, bits 2:0 count partial programs
   logic [3:0] blk_info;
   logic [3:0] blk_wdata;
   logic blk_we;
   logic [BLK_W-1:0] blk_addr;
   logic [BLK_W-1:0] req_blk;

   assign req_blk = req_reg.addr[BLK_W+17:18];
   assign blk_addr = mark_bad ? mark_blk : req_blk;
   always_comb begin
      blk_we = mark_bad;
      blk_wdata = 4'h8;
      if (!mark_bad && state_reg == s_check && !blk_info[3] &&
          req_reg.op != nfc_op_read && req_reg.op != nfc_op_reset) begin
         blk_we = 1'b1;
         blk_wdata = (req_reg.op == nfc_op_erase) ? 4'h0 : blk_info + 4'h1;
      end
   end

   // Block status memory; caller refuses program and erase on invalid blocks
   nfc_bad_mem #(.ADDR_W(BLK_W), .DATA_W(4)) u_mem (
      .ref_clk(ref_clk),
      .wr_en(blk_we),
      .wr_addr(blk_addr),
      .wr_data(blk_wdata),
      .rd_addr(req_ready ? req.addr[BLK_W+17:18] : req_blk),
      .rd_data(blk_info)
   );

   assign req_ready = (state_reg == s_idle);
   assign wdata_ready = (state_reg == s_data) && (tm_reg == 16'h0) && ctl_reg.we_n &&
                        !sent_reg;
   assign ctl = ctl_reg;
   assign io_out = io_out_reg;
   assign io_oe_n = io_oe_n_reg;
   assign rdata = rdata_reg;
   assign rdata_valid = rdata_valid_reg;
   assign done = done_reg;
   assign timeout = timeout_reg;
   assign refused = refused_reg;

   // Strobes each take a low phase then a high phase; lines move while high, except data bytes, which change on the same edge as the strobe falls.
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         state_reg <= s_idle;
         req_reg <= '0;
         ctl_reg <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                      lock_n: 1'b0};
         io_out_reg <= 8'h00;
         io_oe_n_reg <= 1'b1;
         addr_cnt_reg <= 3'h0;
         len_reg <= 16'h0;
         tm_reg <= 16'h0;
         busy_reg <= 32'h0;
         phase_reg <= 2'h0;
         plane2_reg <= 1'b0;
         sent_reg <= 1'b0;
         rdata_valid_reg <= 1'b0;
         rdata_reg <= 8'h00;
         done_reg <= 1'b0;
         timeout_reg <= 1'b0;
         refused_reg <= 1'b0;
      end else begin
         rdata_valid_reg <= 1'b0;
         done_reg <= 1'b0;
         refused_reg <= 1'b0;
         if (tm_reg != 16'h0) tm_reg <= tm_reg - 16'h1;
         unique case (state_reg)
            s_idle: begin
               ctl_reg.ce_n <= 1'b1;
               ctl_reg.cle <= 1'b0;
               ctl_reg.ale <= 1'b0;
               io_oe_n_reg <= 1'b1;
               if (req_valid) begin
                  req_reg <= req;
                  timeout_reg <= 1'b0;
                  plane2_reg <= 1'b0;
                  state_reg <= s_check;
               end
            end
            s_check: begin
               // Memory read data valid this cycle
               if (req_reg.op != nfc_op_read && req_reg.op != nfc_op_reset &&
                   (blk_info[3] || (req_reg.op != nfc_op_erase &&
                    blk_info[2:0] >= `NFC_PARTIAL_PROG_MAX))) begin
                  refused_reg <= 1'b1;
                  state_reg <= s_idle;
               end else begin
                  // Write-type operations release write protect for the whole op
                  ctl_reg.lock_n <= (req_reg.op != nfc_op_read);
                  ctl_reg.ce_n <= 1'b0;
                  ctl_reg.cle <= 1'b1;
                  io_out_reg <= req_reg.cmd1;
                  io_oe_n_reg <= 1'b0;
                  phase_reg <= 2'h0;
                  tm_reg <= WH_CYC;
                  state_reg <= s_cmd1;
               end
            end
            s_cmd1, s_cmd2, s_addr, s_data: begin
               if (tm_reg == 16'h0) begin
                  if (!ctl_reg.we_n) begin
                     // Lines hold one cycle past the rising strobe for hold time
                     ctl_reg.we_n <= 1'b1;
                     sent_reg <= 1'b1;
                     tm_reg <= WH_CYC - 16'h1;
                  end else if (!sent_reg && (state_reg != s_data || wdata_valid)) begin
                     if (state_reg == s_data) io_out_reg <= wdata;
                     ctl_reg.we_n <= 1'b0;
                     tm_reg <= WP_CYC - 16'h1;
                  end else if (sent_reg) begin
                     sent_reg <= 1'b0;
                     unique case (state_reg)
                        s_cmd1: begin
                           ctl_reg.cle <= 1'b0;
                           if (req_reg.op == nfc_op_reset) begin
                              tm_reg <= WB_CYC;
                              state_reg <= s_wb;
                           end else begin
                              ctl_reg.ale <= 1'b1;
                              io_out_reg <= req_reg.addr[7:0];
                              addr_cnt_reg <= 3'h1;
                              state_reg <= s_addr;
                           end
                        end
                        s_addr: begin
                           if (addr_cnt_reg == `NFC_ADDR_CYCLES) begin
                              ctl_reg.ale <= 1'b0;
                              if (req_reg.op == nfc_op_erase) begin
                                 ctl_reg.cle <= 1'b1;
                                 io_out_reg <= req_reg.cmd2;
                                 state_reg <= s_cmd2;
                              end else begin
                                 len_reg <= req_reg.data_len;
                                 tm_reg <= ADL_CYC - WP_CYC;
                                 state_reg <= s_adl;
                              end
                           end else begin
                              io_out_reg <= req_reg.addr[8*addr_cnt_reg +: 8];
                              addr_cnt_reg <= addr_cnt_reg + 3'h1;
                           end
                        end
                        s_data: begin
                           if (len_reg <= 16'h1) begin
                              ctl_reg.cle <= 1'b1;
                              io_out_reg <= (req_reg.op == nfc_op_program_2p && !plane2_reg)
                                 ? `NFC_CMD_PLANE1 : req_reg.cmd2;
                              state_reg <= s_cmd2;
                           end
                           len_reg <= len_reg - 16'h1;
                        end
                        default: begin
                           ctl_reg.cle <= 1'b0;
                           tm_reg <= WB_CYC;
                           busy_reg <= 32'h0;
                           state_reg <= s_wb;
                        end
                     endcase
                  end
               end
            end
            s_adl: begin
               if (tm_reg == 16'h0) begin
                  if (req_reg.op == nfc_op_read) begin
                     ctl_reg.cle <= 1'b1;
                     io_out_reg <= req_reg.cmd2;
                     state_reg <= s_cmd2;
                  end else if (len_reg == 16'h0) begin
                     ctl_reg.cle <= 1'b1;
                     io_out_reg <= req_reg.cmd2;
                     state_reg <= s_cmd2;
                  end else begin
                     state_reg <= s_data;
                  end
               end
            end
            s_wb: begin
               io_oe_n_reg <= 1'b1;
               busy_reg <= 32'h0;
               if (tm_reg == 16'h0) state_reg <= s_busy;
            end
            s_busy: begin
               ctl_reg.oe_n <= 1'b1;
               busy_reg <= busy_reg + 32'h1;
               if (rb_reg) begin
                  if (req_reg.op == nfc_op_program_2p && !plane2_reg) begin
                     state_reg <= s_plane;
                  end else if (req_reg.op == nfc_op_read) begin
                     len_reg <= req_reg.data_len;
                     tm_reg <= WHR_CYC;
                     state_reg <= s_rd;
                  end else begin
                     state_reg <= s_fin;
                  end
               end else if ((req_reg.op == nfc_op_erase && busy_reg >= 32'(ERASE_TMO)) ||
                            (req_reg.op == nfc_op_reset && busy_reg >= RST_TMO) ||
                            (req_reg.op == nfc_op_program_2p && !plane2_reg &&
                             busy_reg >= 32'(`NFC_DBSY_MAX_US * 1000 / CLK_NS)) ||
                            ((req_reg.op == nfc_op_program || req_reg.op == nfc_op_program_2p)
                             && busy_reg >= 32'(PROG_TMO))) begin
                  timeout_reg <= 1'b1;
                  state_reg <= s_fin;
               end
            end
            s_plane: begin
               // Second plane: opening command then full address
               plane2_reg <= 1'b1;
               ctl_reg.cle <= 1'b1;
               io_out_reg <= `NFC_CMD_PLANE2;
               io_oe_n_reg <= 1'b0;
               tm_reg <= WH_CYC;
               state_reg <= s_cmd1;
            end
            s_rd: begin
               io_oe_n_reg <= 1'b1;
               if (tm_reg == 16'h0) begin
                  if (len_reg == 16'h0) begin
                     state_reg <= s_fin;
                  end else if (ctl_reg.oe_n) begin
                     ctl_reg.oe_n <= 1'b0;
                     tm_reg <= RP_CYC + 16'h2;
                  end else begin
                     // Two extra cycles cover the input synchroniser
                     rdata_reg <= io_reg;
                     rdata_valid_reg <= 1'b1;
                     ctl_reg.oe_n <= 1'b1;
                     len_reg <= len_reg - 16'h1;
                     tm_reg <= REH_CYC - 16'h1;
                  end
               end
            end
            s_fin: begin
               // Lock stays high through busy, dropped only at the end
               ctl_reg.lock_n <= 1'b0;
               ctl_reg.ce_n <= 1'b1;
               done_reg <= 1'b1;
               state_reg <= s_idle;
            end
         endcase
      end
   end
endmodule // nfc_host

// *** nfc_dev_model.sv ***
// Behavioural NAND memory model facing the host controller
`timescale 1ns/1ps
module nfc_dev_model
   import nfc_pkg::*;
#(
   parameter int PROG_CYC = 40,
   parameter int ERASE_CYC = 60,
   parameter int SHORT_CYC = 8
)(
   input wire logic ref_clk,
   input wire nfc_ctl_t ctl,
   input wire logic [7:0] io_out,
   input wire logic io_oe_n,
   input wire logic hang,
   output logic [7:0] io_in,
   output logic ready_busy_n
);
   logic [9:0] log_q[$];
   int busy_cnt = 0;
   logic [7:0] rd_ptr = 8'h00;
   logic [7:0] last_q = 8'h00;
   // Released bus shows the inverse of its last value so a stale byte never matches
   assign io_in = (!ctl.ce_n && !ctl.oe_n) ? (rd_ptr ^ 8'ha5) : ~last_q;
   assign ready_busy_n = (busy_cnt == 0);
   // Hang freezes busy so the host's limit can be seen to expire
   always @(posedge ref_clk) begin
      if (busy_cnt > 0 && !hang) busy_cnt <= busy_cnt - 1;
   end
   always @(posedge ctl.we_n) begin
      if (!ctl.ce_n && ctl.oe_n && !(ctl.cle && ctl.ale)) begin
         if (ctl.cle || ctl.ale || ctl.lock_n) log_q.push_back({ctl.cle, ctl.ale, io_out});
         if (ctl.cle) begin
            case (io_out)
               8'h10: if (ctl.lock_n) busy_cnt = PROG_CYC;
               8'hd0: if (ctl.lock_n) busy_cnt = ERASE_CYC;
               8'h11: if (ctl.lock_n) busy_cnt = SHORT_CYC;
               8'h30: begin
                  rd_ptr = 8'h00;
                  busy_cnt = SHORT_CYC;
               end
               8'hff: busy_cnt = SHORT_CYC;
               default: ;
            endcase
         end
      end
   end
   always @(posedge ctl.oe_n) begin
      if (!ctl.ce_n) begin
         last_q = rd_ptr ^ 8'ha5;
         rd_ptr = rd_ptr + 8'h01;
      end
   end
endmodule // nfc_dev_model

// *** nfc_host_checker.sv ***
// Concurrent checks on the NAND host controller pins
`timescale 1ns/1ps
module nfc_host_checker
   import nfc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic timeout,
   input wire logic refused,
   input wire nfc_ctl_t ctl,
   input wire logic [7:0] io_out,
   input wire logic io_oe_n,
   input wire logic ready_busy_n
);
   logic we_prev;
   logic [2:0] acnt;
   logic [7:0] dcnt;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // --------
   // Address count and address-to-data spacing
   // --------
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         we_prev <= 1'b1;
         acnt <= 3'h0;
         dcnt <= 8'hff;
      end else begin
         we_prev <= ctl.we_n;
         if (ctl.we_n && !we_prev && ctl.cle) acnt <= 3'h0;
         else if (ctl.we_n && !we_prev && ctl.ale) acnt <= acnt + 3'h1;
         if (ctl.we_n && !we_prev && ctl.ale) dcnt <= 8'h00;
         else if (dcnt != 8'hff) dcnt <= dcnt + 8'h01;
      end
   end
   sequence s_we_rise;
      $rose(ctl.we_n);
   endsequence
   sequence s_data_in;
      s_we_rise ##0 (!ctl.cle && !ctl.ale && !ctl.ce_n);
   endsequence
   property p_cmd;
      s_we_rise ##0 ctl.cle |-> !ctl.ale && !ctl.ce_n && ctl.oe_n;
   endproperty
   a_cmd: assert property (p_cmd) else $error("command latch pins wrong");
   property p_addr;
      s_we_rise ##0 ctl.ale |-> !ctl.cle && !ctl.ce_n && ctl.oe_n;
   endproperty
   a_addr: assert property (p_addr) else $error("address latch pins wrong");
   property p_five;
      s_we_rise ##0 ctl.cle |-> acnt == 3'h0 || acnt == 3'h5;
   endproperty
   a_five: assert property (p_five) else $error("address phase not five bytes");
   property p_wlock;
      s_we_rise ##0 ctl.cle && (io_out == 8'h80 || io_out == 8'h60) |-> ctl.lock_n;
   endproperty
   a_wlock: assert property (p_wlock) else $error("write command with lock low");
   property p_dlock;
      s_data_in |-> ctl.lock_n;
   endproperty
   a_dlock: assert property (p_dlock) else $error("data byte with lock low");
   property p_rd;
      !ctl.oe_n |-> ctl.we_n && !ctl.ce_n && io_oe_n;
   endproperty
   a_rd: assert property (p_rd) else $error("read strobe with bus clash");
   property p_busy_re;
      !ready_busy_n |-> ctl.oe_n;
   endproperty
   a_busy_re: assert property (p_busy_re) else $error("read strobe while busy");
   property p_lock;
      $fell(ctl.lock_n) && !timeout |-> $past(ready_busy_n) && $past(ready_busy_n, 2);
   endproperty
   a_lock: assert property (p_lock) else $error("lock dropped during busy");
   property p_stable;
      !ctl.we_n && !$fell(ctl.we_n) |-> $stable(ctl.cle) && $stable(ctl.ale)
         && $stable(ctl.ce_n) && $stable(io_out);
   endproperty
   a_stable: assert property (p_stable) else $error("line moved in strobe low");
   property p_adl;
      s_data_in |-> dcnt >= 8'h06;
   endproperty
   a_adl: assert property (p_adl) else $error("data too soon after address");
   property p_quiet;
      refused |-> ctl.ce_n && ctl.we_n && io_oe_n;
   endproperty
   a_quiet: assert property (p_quiet) else $error("bus active on refusal");
endmodule // nfc_host_checker
bind nfc_host nfc_host_checker chk_u (.ref_clk(ref_clk), .nrst(nrst), .timeout(timeout),
   .refused(refused), .ctl(ctl), .io_out(io_out), .io_oe_n(io_oe_n),
   .ready_busy_n(ready_busy_n));

// *** testbench.sv ***
// Self-checking bench for the NAND host controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; \
   $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module testbench
   import nfc_pkg::*;
;
   localparam int PC = 40;
   localparam int EC = 60;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic req_valid = 1'b0;
   logic wdata_valid = 1'b1;
   logic mark_bad = 1'b0;
   logic hang = 1'b0;
   logic [11:0] mark_blk = 12'h000;
   logic [7:0] widx = 8'h00;
   nfc_req_t req = '0;
   logic req_ready, wdata_ready, rdata_valid, done, timeout, refused, rb_n, io_oe_n;
   logic [7:0] rdata, io_out, io_in;
   nfc_ctl_t ctl;
   logic [7:0] rq[$];
   int fails = 0;
   int compares = 0;
   int cyc;
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (wdata_valid && wdata_ready) widx <= widx + 8'h01;
      if (rdata_valid) rq.push_back(rdata);
   end
   nfc_host #(.PROG_TMO(200), .ERASE_TMO(300)) dut_u (.ref_clk(ref_clk), .nrst(nrst),
      .req_valid(req_valid), .req_ready(req_ready), .req(req), .wdata_valid(wdata_valid),
      .wdata_ready(wdata_ready), .wdata(widx ^ 8'h30), .rdata_valid(rdata_valid),
      .rdata(rdata), .done(done), .timeout(timeout), .refused(refused), .mark_bad(mark_bad),
      .mark_blk(mark_blk), .ctl(ctl), .io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_in),
      .ready_busy_n(rb_n));
   nfc_dev_model #(.PROG_CYC(PC), .ERASE_CYC(EC)) dev_u (.ref_clk(ref_clk), .ctl(ctl),
      .io_out(io_out), .io_oe_n(io_oe_n), .hang(hang), .io_in(io_in), .ready_busy_n(rb_n));
   // --------
   // Shared request and log helpers
   // --------
   function automatic logic [9:0] ent(input int i);
      return (i < dev_u.log_q.size()) ? dev_u.log_q[i] : 10'h3ff;
   endfunction
   task automatic run_op(input nfc_op_t op, input logic [7:0] c1, input logic [7:0] c2,
         input logic [11:0] blk, input logic [15:0] n);
      dev_u.log_q.delete();
      rq.delete();
      @(posedge ref_clk);
      #1;
      widx = 8'h00;
      req = '{op, c1, c2, {10'h000, blk, 18'h00123}, n};
      req_valid = 1'b1;
      for (cyc = 0; cyc < 50 && req_ready !== 1'b1; cyc++) begin
         @(posedge ref_clk);
         #1;
      end
      @(posedge ref_clk);
      #1;
      req_valid = 1'b0;
      for (cyc = 0; cyc < 3000; cyc++) begin
         @(posedge ref_clk);
         #1;
         if (done === 1'b1 || refused === 1'b1 || timeout === 1'b1) break;
      end
   endtask
   task automatic chk_addr(input int at, input logic [11:0] blk);
      logic [39:0] a;
      a = {10'h000, blk, 18'h00123};
      for (int k = 0; k < 5; k++) `CHK("addr", {2'b01, a[8*k+:8]}, ent(at + k))
   endtask
   // --------
   // Scenarios
   // --------
   task automatic t_program();
      run_op(nfc_op_program, 8'h80, 8'h10, 12'h011, 16'h0003);
      `CHK("done", 1'b1, done)
      `CHK("prog busy", 1'b1, cyc >= PC)
      `CHK("cmd1", {2'b10, 8'h80}, ent(0))
      chk_addr(1, 12'h011);
      for (int k = 0; k < 3; k++) `CHK("wdata", {2'b00, 8'(k) ^ 8'h30}, ent(6 + k))
      `CHK("cmd2", {2'b10, 8'h10}, ent(9))
   endtask
   task automatic t_read();
      run_op(nfc_op_read, 8'h00, 8'h30, 12'h012, 16'h0004);
      @(posedge ref_clk);
      #1;
      chk_addr(1, 12'h012);
      `CHK("read cmd2", {2'b10, 8'h30}, ent(6))
      `CHK("read count", 4, rq.size())
      for (int k = 0; k < 4; k++) `CHK("rdata", 8'(k) ^ 8'ha5, rq[k])
   endtask
   task automatic t_partial();
      run_op(nfc_op_erase, 8'h60, 8'hd0, 12'h013, 16'h0000);
      `CHK("erase busy", 1'b1, cyc >= EC)
      `CHK("erase cmd2", {2'b10, 8'hd0}, ent(6))
      for (int k = 0; k < 5; k++) begin
         run_op(nfc_op_program, 8'h80, 8'h10, 12'h013, 16'h0001);
         `CHK("partial", k == 4, refused)
      end
      `CHK("quiet bus", 0, dev_u.log_q.size())
      run_op(nfc_op_erase, 8'h60, 8'hd0, 12'h013, 16'h0000);
      run_op(nfc_op_program, 8'h80, 8'h10, 12'h013, 16'h0001);
      `CHK("after erase", 1'b0, refused)
   endtask
   task automatic t_bad();
      @(posedge ref_clk);
      #1;
      mark_blk = 12'h0ab;
      mark_bad = 1'b1;
      @(posedge ref_clk);
      #1;
      mark_bad = 1'b0;
      run_op(nfc_op_program, 8'h80, 8'h10, 12'h0ab, 16'h0001);
      `CHK("bad prog", 1'b1, refused)
      run_op(nfc_op_erase, 8'h60, 8'hd0, 12'h0ab, 16'h0000);
      `CHK("bad erase", 1'b1, refused)
      run_op(nfc_op_program, 8'h80, 8'h10, 12'h0ac, 16'h0001);
      `CHK("neighbour", 1'b0, refused)
   endtask
   task automatic t_misc();
      run_op(nfc_op_program_2p, 8'h80, 8'h10, 12'h014, 16'h0002);
      `CHK("plane1 end", {2'b10, 8'h11}, ent(8))
      `CHK("plane2 start", {2'b10, 8'h81}, ent(9))
      `CHK("plane2 end", {2'b10, 8'h10}, ent(17))
      hang = 1'b1;
      run_op(nfc_op_program, 8'h80, 8'h10, 12'h015, 16'h0001);
      `CHK("timeout", 1'b1, timeout)
      hang = 1'b0;
      repeat (PC) @(posedge ref_clk);
      run_op(nfc_op_reset, 8'hff, 8'h00, 12'h000, 16'h0000);
      `CHK("reset done", 1'b1, done)
      `CHK("reset cmd", {2'b10, 8'hff}, ent(0))
      `CHK("reset span", 1'b1, cyc < 500)
   endtask
   task automatic conclude();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      #1;
      nrst = 1'b1;
      t_program();
      t_read();
      t_partial();
      t_bad();
      t_misc();
      conclude();
   end
   // Far above the few thousand cycles the scenarios need
   initial begin
      #500000;
      fails++;
      conclude();
   end
endmodule // testbench
